// ===== verilog/srg_pkg.sv
package srg_pkg;

	// Levels in hundredths of a percent, signed
	localparam int PCT_W = 17;
	localparam int TIME_W = 13;
	localparam int FRAC_W = 16;
	localparam int LVL_W = PCT_W + FRAC_W;
	localparam int STEP_W = 20;
	localparam logic signed [PCT_W-1:0] FULL_SCALE = 17'sh02710;
	localparam logic signed [PCT_W-1:0] PRESET_MAX = 17'sh07530;
	localparam logic [13:0] MIN_HYST = 14'h0032;

	// Durations in tenths of a second
	localparam logic [TIME_W-1:0] TIME_MIN = 13'h0001;
	localparam logic [TIME_W-1:0] TIME_MAX = 13'h1770;
	localparam logic [TIME_W-1:0] TIME_DEF = 13'h0064;

	// Timing
	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_US = 100;
	localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
	localparam int TICKS_PER_TENTH = 100_000 / TICK_US;
	localparam int SYSRST_MS = 5;
	localparam int SYSRST_CYCLES = SYSRST_MS * (CLK_HZ / 1000);
	localparam logic [STEP_W-1:0] STEP_NUM =
		STEP_W'((10000 << FRAC_W) / TICKS_PER_TENTH);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FWD_UP = 8'h04;
	localparam logic [7:0] OFS_FWD_DOWN = 8'h08;
	localparam logic [7:0] OFS_REV_UP = 8'h0C;
	localparam logic [7:0] OFS_REV_DOWN = 8'h10;
	localparam logic [7:0] OFS_JOG_TIME = 8'h14;
	localparam logic [7:0] OFS_STOP_TIME = 8'h18;
	localparam logic [7:0] OFS_FWD_MIN = 8'h1C;
	localparam logic [7:0] OFS_REV_MIN = 8'h20;
	localparam logic [7:0] OFS_PRESET = 8'h24;
	localparam logic [7:0] OFS_SHAPE = 8'h28;
	localparam logic [7:0] OFS_THRESH = 8'h2C;
	localparam logic [7:0] OFS_INPUT = 8'h30;
	localparam logic [7:0] OFS_MONITOR = 8'h34;
	localparam logic [7:0] OFS_STATUS = 8'h38;

	// Control fields
	localparam int CTRL_W = 4;
	localparam int CB_AUTO = 0;
	localparam int CB_EXT = 1;
	localparam int CB_HOLD = 2;
	localparam int CB_TERM = 3;
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h9;
	localparam logic [13:0] THRESH_RST = 14'h00FA;

	typedef struct packed {
		logic run;
		logic jog;
		logic stop;
		logic ext_preset;
		logic contactor;
	} srg_cmd_s;

endpackage

// ===== verilog/srg_sync.sv
module srg_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} srg_sync_s;

	srg_sync_s st_reg;
	srg_sync_s st_next;

	always_comb
	begin
		st_next.meta = async_in;
		st_next.sync = st_reg.meta;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign sync_out = st_reg.sync;

endmodule

// ===== verilog/srg_div.sv
module srg_div (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Request
	input wire logic go,
	input wire logic [srg_pkg::STEP_W-1:0] num,
	input wire logic [srg_pkg::TIME_W-1:0] den,
	// Result
	output logic done,
	output logic [srg_pkg::STEP_W-1:0] quo
);

	typedef struct packed {
		logic busy;
		logic done;
		logic [4:0] cnt;
		logic [srg_pkg::TIME_W:0] rem;
		logic [srg_pkg::STEP_W-1:0] q;
		logic [srg_pkg::TIME_W-1:0] d;
	} srg_div_s;

	srg_div_s st_reg;
	srg_div_s st_next;
	logic [srg_pkg::TIME_W+1:0] trial;

	// Restoring division, one quotient bit per clock
	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		trial = {st_reg.rem, st_reg.q[srg_pkg::STEP_W-1]};
		if (go && !st_reg.busy)
		begin
			st_next.busy = 1'b1;
			st_next.cnt = 5'(srg_pkg::STEP_W);
			st_next.rem = '0;
			st_next.q = num;
			st_next.d = den;
		end
		else if (st_reg.busy)
		begin
			st_next.q = {st_reg.q[srg_pkg::STEP_W-2:0], 1'b0};
			if (trial >= {2'b00, st_reg.d})
			begin
				st_next.rem = (srg_pkg::TIME_W+1)'(trial - {2'b00, st_reg.d});
				st_next.q[0] = 1'b1;
			end
			else
				st_next.rem = (srg_pkg::TIME_W+1)'(trial);
			st_next.cnt = st_reg.cnt - 5'h01;
			if (st_reg.cnt == 5'h01)
			begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign done = st_reg.done;
	assign quo = st_reg.q;

endmodule

// ===== verilog/srg_ramp.sv
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
module srg_ramp #(
	parameter int TICK_CYCLES = srg_pkg::TICK_CYCLES,
	parameter int SYSRST_CYCLES = srg_pkg::SYSRST_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Drive command pins
	input wire logic run_request,
	input wire logic jog_request,
	input wire logic stop_request,
	input wire logic external_preset_request,
	input wire logic contactor_energised,
	// Reference from analogue input, same clock
	input wire logic signed [16:0] analogue_reference_terminal,
	// To speed loop
	output logic signed [16:0] output_level_readback,
	output logic ramping_flag,
	output logic system_reset_pulse
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [srg_pkg::CTRL_W-1:0] ctrl;
		logic [srg_pkg::TIME_W-1:0] t_fu;
		logic [srg_pkg::TIME_W-1:0] t_fd;
		logic [srg_pkg::TIME_W-1:0] t_ru;
		logic [srg_pkg::TIME_W-1:0] t_rd;
		logic [srg_pkg::TIME_W-1:0] t_jog;
		logic [srg_pkg::TIME_W-1:0] t_stop;
		logic [13:0] fmin;
		logic [13:0] rmin;
		logic signed [srg_pkg::PCT_W-1:0] preset;
		logic [3:0] shape;
		logic [13:0] thresh;
		logic signed [srg_pkg::PCT_W-1:0] ref_set;
		logic signed [srg_pkg::LVL_W-1:0] level;
		logic signed [srg_pkg::LVL_W-1:0] smooth;
		logic [srg_pkg::STEP_W-1:0] step;
		logic [31:0] tick_cnt;
		logic [31:0] sr_cnt;
		logic sr_pulse;
		logic cont_d;
		logic run_d;
		logic jog_d;
		logic neg_side;
		logic ramping;
		logic signed [srg_pkg::PCT_W-1:0] out;
	} srg_ramp_s;

	srg_ramp_s st_reg;
	srg_ramp_s st_next;
	srg_pkg::srg_cmd_s cmd;
	logic div_done;
	logic [srg_pkg::STEP_W-1:0] div_quo;
	logic tick;
	logic [srg_pkg::TIME_W-1:0] t_sel;
	logic signed [srg_pkg::PCT_W-1:0] ref_in;
	logic signed [srg_pkg::PCT_W-1:0] tgt;
	logic signed [srg_pkg::PCT_W-1:0] fmin_s;
	logic signed [srg_pkg::PCT_W-1:0] rmin_s;
	logic signed [srg_pkg::PCT_W-1:0] lvl_int;
	logic signed [srg_pkg::PCT_W:0] err;
	logic signed [srg_pkg::LVL_W:0] diff;
	logic signed [srg_pkg::LVL_W:0] stp;
	logic signed [srg_pkg::LVL_W-1:0] preset_lvl;
	logic fmin_on;
	logic rmin_on;
	logic stopped;
	logic mode_off;
	logic ext_on;
	logic mom_preset;
	logic rising;
	logic wr;
	logic [31:0] wd;

	srg_sync #(
		.W($bits(srg_pkg::srg_cmd_s))
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.async_in({run_request, jog_request, stop_request,
			external_preset_request, contactor_energised}),
		.sync_out(cmd)
	);

	srg_div u_div (
		.mclk(mclk),
		.rst(rst),
		.go(tick),
		.num(srg_pkg::STEP_NUM),
		.den(t_sel),
		.done(div_done),
		.quo(div_quo)
	);

	// Byte-lane merge of a write into a field
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction

	// Durations clamp into their settable range
	function automatic logic [srg_pkg::TIME_W-1:0] tclamp(
		input logic [31:0] v);
		logic [srg_pkg::TIME_W-1:0] r;
		r = srg_pkg::TIME_MAX;
		if (v < 32'(srg_pkg::TIME_MIN))
			r = srg_pkg::TIME_MIN;
		else if (v < 32'(srg_pkg::TIME_MAX))
			r = srg_pkg::TIME_W'(v);
		return r;
	endfunction

	function automatic logic signed [srg_pkg::PCT_W-1:0] pclamp(
		input logic signed [srg_pkg::PCT_W-1:0] v,
		input logic signed [srg_pkg::PCT_W-1:0] lim);
		logic signed [srg_pkg::PCT_W-1:0] r;
		r = v;
		if (v > lim)
			r = lim;
		else if (v < -lim)
			r = -lim;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reference conditioning and mode decode

	always_comb
	begin
		tick = st_reg.tick_cnt == 32'(TICK_CYCLES - 1);
		ext_on = st_reg.ctrl[srg_pkg::CB_EXT] | cmd.ext_preset;
		mode_off = !st_reg.ctrl[srg_pkg::CB_AUTO] && !ext_on;
		stopped = !cmd.run && !cmd.jog;
		ref_in = st_reg.ctrl[srg_pkg::CB_TERM] ?
			analogue_reference_terminal : st_reg.ref_set;
		fmin_on = st_reg.fmin > srg_pkg::MIN_HYST;
		rmin_on = st_reg.rmin > srg_pkg::MIN_HYST;
		fmin_s = srg_pkg::PCT_W'(signed'({1'b0, st_reg.fmin}));
		rmin_s = srg_pkg::PCT_W'(signed'({1'b0, st_reg.rmin}));
		tgt = ref_in;
		if (!st_reg.neg_side && fmin_on && ref_in < fmin_s)
			tgt = fmin_s;
		else if (st_reg.neg_side && rmin_on && ref_in > -rmin_s)
			tgt = -rmin_s;
		tgt = pclamp(tgt, srg_pkg::FULL_SCALE);
		if (mode_off && stopped)
			tgt = '0;
		preset_lvl = srg_pkg::LVL_W'(
			pclamp(st_reg.preset, srg_pkg::FULL_SCALE)) <<< srg_pkg::FRAC_W;
		// Momentary presets: start edges, jog edge, auto with reset pulse
		mom_preset = (!mode_off && ((cmd.run && !st_reg.run_d) ||
			(cmd.jog && !st_reg.jog_d)))
			|| (ext_on && cmd.jog && !st_reg.jog_d)
			|| (st_reg.ctrl[srg_pkg::CB_AUTO] && st_reg.sr_pulse);
		lvl_int = srg_pkg::PCT_W'(st_reg.level >>> srg_pkg::FRAC_W);
		diff = (srg_pkg::LVL_W+1)'(signed'(tgt)) <<< srg_pkg::FRAC_W;
		diff = diff - (srg_pkg::LVL_W+1)'(st_reg.level);
		stp = (srg_pkg::LVL_W+1)'(signed'({1'b0, st_reg.step}));
		// Magnitude rising when target lies further from zero
		rising = (lvl_int >= 0) ? (tgt > lvl_int) : (tgt < lvl_int);
		if (cmd.jog)
			t_sel = st_reg.t_jog;
		else if (cmd.stop && !rising)
			t_sel = st_reg.t_stop;
		else if (cmd.stop)
			t_sel = st_reg.t_stop;
		else if (lvl_int >= 0)
			t_sel = rising ? st_reg.t_fu : st_reg.t_fd;
		else
			t_sel = rising ? st_reg.t_ru : st_reg.t_rd;
		err = (srg_pkg::PCT_W+1)'(tgt) - (srg_pkg::PCT_W+1)'(st_reg.out);
		if (err < 0)
			err = -err;
	end

	////////////////////////////////////////////////////////////////////////
	// Register file, ramp integrator and system reset pulse

	always_comb
	begin
		st_next = st_reg;
		wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_reg.ack;
		st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
		st_next.rdat = '0;
		wd = '0;
		unique case (wb_adr_i)
			srg_pkg::OFS_CTRL: wd = 32'(st_reg.ctrl);
			srg_pkg::OFS_FWD_UP: wd = 32'(st_reg.t_fu);
			srg_pkg::OFS_FWD_DOWN: wd = 32'(st_reg.t_fd);
			srg_pkg::OFS_REV_UP: wd = 32'(st_reg.t_ru);
			srg_pkg::OFS_REV_DOWN: wd = 32'(st_reg.t_rd);
			srg_pkg::OFS_JOG_TIME: wd = 32'(st_reg.t_jog);
			srg_pkg::OFS_STOP_TIME: wd = 32'(st_reg.t_stop);
			srg_pkg::OFS_FWD_MIN: wd = 32'(st_reg.fmin);
			srg_pkg::OFS_REV_MIN: wd = 32'(st_reg.rmin);
			srg_pkg::OFS_PRESET: wd = 32'(signed'(st_reg.preset));
			srg_pkg::OFS_SHAPE: wd = 32'(st_reg.shape);
			srg_pkg::OFS_THRESH: wd = 32'(st_reg.thresh);
			srg_pkg::OFS_INPUT: wd = 32'(signed'(ref_in));
			srg_pkg::OFS_MONITOR: wd = 32'(signed'(st_reg.out));
			srg_pkg::OFS_STATUS: wd = {27'h0, st_reg.sr_pulse, cmd.stop,
				cmd.jog, cmd.run, st_reg.ramping};
			default: wd = '0;
		endcase
		if (wb_cyc_i && wb_stb_i && !st_reg.ack && !wb_we_i)
			st_next.rdat = wd;
		if (wr)
		begin
			wd = merge(wd, wb_dat_i, wb_sel_i);
			unique case (wb_adr_i)
				srg_pkg::OFS_CTRL: st_next.ctrl = wd[srg_pkg::CTRL_W-1:0];
				srg_pkg::OFS_FWD_UP: st_next.t_fu = tclamp(wd);
				srg_pkg::OFS_FWD_DOWN: st_next.t_fd = tclamp(wd);
				srg_pkg::OFS_REV_UP: st_next.t_ru = tclamp(wd);
				srg_pkg::OFS_REV_DOWN: st_next.t_rd = tclamp(wd);
				srg_pkg::OFS_JOG_TIME: st_next.t_jog = tclamp(wd);
				srg_pkg::OFS_STOP_TIME: st_next.t_stop = tclamp(wd);
				srg_pkg::OFS_FWD_MIN: st_next.fmin = (wd >
					32'(srg_pkg::FULL_SCALE)) ? 14'(srg_pkg::FULL_SCALE) :
					wd[13:0];
				srg_pkg::OFS_REV_MIN: st_next.rmin = (wd >
					32'(srg_pkg::FULL_SCALE)) ? 14'(srg_pkg::FULL_SCALE) :
					wd[13:0];
				srg_pkg::OFS_PRESET: st_next.preset = pclamp(
					wd[srg_pkg::PCT_W-1:0], srg_pkg::PRESET_MAX);
				srg_pkg::OFS_SHAPE: st_next.shape = wd[3:0];
				srg_pkg::OFS_THRESH: st_next.thresh = (wd >
					32'(srg_pkg::FULL_SCALE)) ? 14'(srg_pkg::FULL_SCALE) :
					wd[13:0];
				srg_pkg::OFS_INPUT: st_next.ref_set = pclamp(
					wd[srg_pkg::PCT_W-1:0], srg_pkg::PRESET_MAX);
				default: st_next.ctrl = st_reg.ctrl;
			endcase
		end

		// Edge history and tick base
		st_next.cont_d = cmd.contactor;
		st_next.run_d = cmd.run;
		st_next.jog_d = cmd.jog;
		st_next.tick_cnt = tick ? '0 : st_reg.tick_cnt + 32'h1;

		// One pulse per contactor energisation
		if (cmd.contactor && !st_reg.cont_d)
		begin
			st_next.sr_pulse = 1'b1;
			st_next.sr_cnt = 32'(SYSRST_CYCLES - 1);
		end
		else if (st_reg.sr_cnt != '0)
			st_next.sr_cnt = st_reg.sr_cnt - 32'h1;
		else
			st_next.sr_pulse = 1'b0;

		// Sign side with hysteresis around zero
		if (fmin_on && !rmin_on)
			st_next.neg_side = 1'b0;
		else if (ref_in < -srg_pkg::PCT_W'(signed'({1'b0, srg_pkg::MIN_HYST})))
			st_next.neg_side = 1'b1;
		else if (ref_in > srg_pkg::PCT_W'(signed'({1'b0, srg_pkg::MIN_HYST})))
			st_next.neg_side = 1'b0;

		if (div_done)
			st_next.step = div_quo;

		// Integrator; external preset outranks hold
		if (ext_on && !cmd.jog)
			st_next.level = preset_lvl;
		else if (mom_preset)
			st_next.level = preset_lvl;
		else if (mode_off && stopped)
			st_next.level = '0;
		else if (st_reg.ctrl[srg_pkg::CB_HOLD])
			st_next.level = st_reg.level;
		else if (tick)
		begin
			if (diff <= stp && diff >= -stp)
				st_next.level = srg_pkg::LVL_W'(
					(srg_pkg::LVL_W+1)'(st_reg.level) + diff);
			else if (diff > 0)
				st_next.level = srg_pkg::LVL_W'(
					(srg_pkg::LVL_W+1)'(st_reg.level) + stp);
			else
				st_next.level = srg_pkg::LVL_W'(
					(srg_pkg::LVL_W+1)'(st_reg.level) - stp);
		end

		// First-order smoothing rounds the corners into an S
		if (st_reg.shape == '0 || st_next.level != st_reg.level && !tick)
			st_next.smooth = st_next.level;
		else if (tick)
			st_next.smooth = st_reg.smooth +
				((st_reg.level - st_reg.smooth) >>> st_reg.shape);
		st_next.out = pclamp(srg_pkg::PCT_W'(st_reg.smooth >>>
			srg_pkg::FRAC_W), srg_pkg::FULL_SCALE);
		st_next.ramping = err > (srg_pkg::PCT_W+1)'(st_reg.thresh);
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_reg <= '0;
			st_reg.ctrl <= srg_pkg::CTRL_RST;
			st_reg.t_fu <= srg_pkg::TIME_DEF;
			st_reg.t_fd <= srg_pkg::TIME_DEF;
			st_reg.t_ru <= srg_pkg::TIME_DEF;
			st_reg.t_rd <= srg_pkg::TIME_DEF;
			st_reg.t_jog <= srg_pkg::TIME_DEF;
			st_reg.t_stop <= srg_pkg::TIME_DEF;
			st_reg.thresh <= srg_pkg::THRESH_RST;
		end
		else
			st_reg <= st_next;
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.rdat;
	assign output_level_readback = st_reg.out;
	assign ramping_flag = st_reg.ramping;
	assign system_reset_pulse = st_reg.sr_pulse;

endmodule

// ===== sim/srg_ramp_asserts.sv
module srg_ramp_asserts #(
	parameter int TICK_CYCLES = 64,
	parameter int SYSRST_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Drive command pins
	input wire logic run_request,
	input wire logic jog_request,
	input wire logic stop_request,
	input wire logic external_preset_request,
	input wire logic contactor_energised,
	input wire logic signed [16:0] analogue_reference_terminal,
	// Ramp outputs
	input wire logic signed [16:0] output_level_readback,
	input wire logic ramping_flag,
	input wire logic system_reset_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	int pulse_cnt;
	logic [3:0] ctrl;
	////////////////////////////////////////
	// Pulse length and control mirror
	always_ff @(posedge mclk)
	begin
		if (rst || !system_reset_pulse)
			pulse_cnt <= 0;
		else
			pulse_cnt <= pulse_cnt + 1;
	end
	always_ff @(posedge mclk)
	begin
		if (rst)
			ctrl <= 4'h9;
		else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
			ctrl <= wb_dat_i[3:0];
	end
	////////////////////////////////////////
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	sequence s_stopped;
		(ctrl[1:0] == 2'h0 && !run_request && !jog_request
			&& !external_preset_request)[*8];
	endsequence
	property p_ack_once;
		s_req |=> s_ack;
	endproperty
	property p_idle_ack;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	property p_dat_idle;
		!wb_ack_o |-> wb_dat_o == 32'h0000_0000;
	endproperty
	property p_range;
		output_level_readback <= 17'sh02710
			&& output_level_readback >= -17'sh02710;
	endproperty
	property p_reset;
		$fell(rst) |-> output_level_readback == 17'sh00000
			&& !ramping_flag && !system_reset_pulse;
	endproperty
	property p_pulse_len;
		$fell(system_reset_pulse) |-> pulse_cnt == SYSRST_CYCLES;
	endproperty
	property p_pulse_cause;
		$rose(system_reset_pulse) |-> $past(contactor_energised);
	endproperty
	property p_mode1_stop;
		s_stopped |-> output_level_readback == 17'sh00000;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack missing or too long");
	a_idle_ack: assert property (p_idle_ack)
		else $error("ack without request");
	a_dat_idle: assert property (p_dat_idle)
		else $error("read data not zero outside ack");
	a_range: assert property (p_range)
		else $error("output beyond full scale");
	a_reset: assert property (p_reset)
		else $error("outputs not cleared by reset");
	a_pulse_len: assert property (p_pulse_len)
		else $error("system reset pulse length wrong");
	a_pulse_cause: assert property (p_pulse_cause)
		else $error("system reset pulse without contactor");
	a_mode1_stop: assert property (p_mode1_stop)
		else $error("output not zero while stopped");
endmodule

bind srg_ramp srg_ramp_asserts #(
	.TICK_CYCLES(TICK_CYCLES),
	.SYSRST_CYCLES(SYSRST_CYCLES)
) i_srg_ramp_asserts (
	.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.run_request(run_request), .jog_request(jog_request),
	.stop_request(stop_request),
	.external_preset_request(external_preset_request),
	.contactor_energised(contactor_energised),
	.analogue_reference_terminal(analogue_reference_terminal),
	.output_level_readback(output_level_readback),
	.ramping_flag(ramping_flag), .system_reset_pulse(system_reset_pulse)
);

// ===== sim/srg_ref_src.sv
module srg_ref_src (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Level asked for, slow update option
	input wire logic slow,
	input wire logic signed [16:0] lvl_cmd,
	// Reference to the ramp
	output logic signed [16:0] ref_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] div_reg;
	// Slow mode updates one cycle in eight
	always_ff @(posedge mclk)
	begin
		div_reg <= rst ? 3'h0 : div_reg + 3'h1;
		if (rst)
			ref_o <= 17'sh00000;
		else if (!slow || div_reg == 3'h0)
			ref_o <= lvl_cmd;
	end
endmodule

// ===== sim/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TC = 64;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0000_0000;
	logic [31:0] wb_rdat, rd;
	logic wb_ack, ramp_flag, sys_pulse;
	logic run_req = 1'b0;
	logic jog_req = 1'b0;
	logic ext_req = 1'b0;
	logic contactor = 1'b0;
	logic ref_slow = 1'b0;
	logic signed [16:0] ref_cmd = 17'sh00000;
	logic signed [16:0] ref_lvl, out_lvl;
	int fail_count = 0;
	int n_tests = 0;
	int seed = 44438;
	int regm [16];
	int i, k, v, c;

	always #2.5 mclk = ~mclk;

	srg_ref_src i_srg_ref_src (
		.mclk(mclk), .rst(rst), .slow(ref_slow), .lvl_cmd(ref_cmd),
		.ref_o(ref_lvl)
	);
	srg_ramp #(.TICK_CYCLES(TC), .SYSRST_CYCLES(20)) i_srg_ramp (
		.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
		.wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.run_request(run_req), .jog_request(jog_req), .stop_request(1'b0),
		.external_preset_request(ext_req), .contactor_energised(contactor),
		.analogue_reference_terminal(ref_lvl),
		.output_level_readback(out_lvl), .ramping_flag(ramp_flag),
		.system_reset_pulse(sys_pulse)
	);
	////////////////////////////////////////
	task conclude;
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task bail;
		fail_count++;
		conclude();
	endtask
	task chk(input logic signed [31:0] got, input int exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input int d);
		int n;
		{wb_cyc, wb_stb, wb_we} <= {2'b11, w};
		wb_adr <= a;
		wb_wdat <= d;
		n = 0;
		@(posedge mclk);
		while (wb_ack !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			n++;
		end
		if (n == 40)
			bail();
		rd = wb_rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
		@(posedge mclk);
	endtask
	task rdc(input logic [7:0] a, input int exp);
		acc(1'b0, a, 0);
		chk(rd, exp);
	endtask
	task automatic wait_out(input int t, input int lim);
		c = 0;
		while (out_lvl !== t && c < lim)
		begin
			@(posedge mclk);
			c++;
		end
		if (c == lim)
			bail();
	endtask
	// Ramp to target, duration in ticks within a small window
	task automatic meas(input int t, input int ticks);
		repeat (40) @(posedge mclk);
		chk(ramp_flag, 1);
		wait_out(t, 40000);
		c = c + 40;
		chk(c > (ticks - 2) * TC && c < (ticks + 3) * TC, 1);
		repeat (4) @(posedge mclk);
		chk(ramp_flag, 0);
	endtask
	////////////////////////////////////////
	initial
	begin
		for (i = 0; i < 16; i++)
			regm[i] = (i == 0) ? 9 : (i < 7) ? 100 : (i == 11) ? 250 : 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		for (i = 0; i < 16; i++)
			rdc(8'(i * 4), regm[i]);
		acc(1'b1, 8'h34, 5555);
		rdc(8'h34, 0);
		ref_slow <= 1'b1;
		ref_cmd <= 17'sh00309;
		repeat (12) @(posedge mclk);
		rdc(8'h30, 777);
		for (i = 1; i < 7; i++)
			for (k = 0; k < 3; k++)
			begin
				v = $unsigned($random(seed)) % 6000 + 1;
				if (k < 2)
					v = k * 9000;
				acc(1'b1, 8'(i * 4), v);
				regm[i] = (v < 1) ? 1 : (v > 6000) ? 6000 : v;
				rdc(8'(i * 4), regm[i]);
			end
		acc(1'b1, 8'h2C, 20000);
		rdc(8'h2C, 10000);
		acc(1'b1, 8'h2C, 250);
		acc(1'b1, 8'h00, 0);
		acc(1'b1, 8'h04, 1);
		acc(1'b1, 8'h08, 2);
		acc(1'b1, 8'h0C, 1);
		acc(1'b1, 8'h10, 2);
		acc(1'b1, 8'h30, 1000);
		repeat (40) @(posedge mclk);
		chk(out_lvl, 0);
		run_req <= 1'b1;
		meas(1000, 100);
		acc(1'b1, 8'h30, 500);
		meas(500, 100);
		acc(1'b1, 8'h30, -500);
		meas(-500, 150);
		acc(1'b1, 8'h30, -100);
		meas(-100, 80);
		run_req <= 1'b0;
		repeat (8) @(posedge mclk);
		chk(out_lvl, 0);
		// Hold, then external preset over it
		acc(1'b1, 8'h00, 4);
		run_req <= 1'b1;
		acc(1'b1, 8'h30, 800);
		repeat (200) @(posedge mclk);
		chk(out_lvl, 0);
		chk(ramp_flag, 1);
		v = $unsigned($random(seed)) % 200 + 300;
		acc(1'b1, 8'h24, v);
		ext_req <= 1'b1;
		repeat (8) @(posedge mclk);
		chk(out_lvl, v);
		ext_req <= 1'b0;
		repeat (20) @(posedge mclk);
		chk(out_lvl, v);
		// Automatic preset only
		acc(1'b1, 8'h00, 1);
		run_req <= 1'b0;
		meas(800, (800 - v) / 10);
		contactor <= 1'b1;
		c = 0;
		while (sys_pulse !== 1'b1 && c < 20)
		begin
			@(posedge mclk);
			c++;
		end
		chk(c < 20, 1);
		repeat (6) @(posedge mclk);
		chk(out_lvl, v);
		wait_out(800, 40000);
		run_req <= 1'b1;
		wait_out(v, 12);
		chk(out_lvl, v);
		// Jog from the preset level with external preset enabled
		run_req <= 1'b0;
		acc(1'b1, 8'h14, 1);
		acc(1'b1, 8'h00, 2);
		repeat (8) @(posedge mclk);
		chk(out_lvl, v);
		jog_req <= 1'b1;
		meas(800, (800 - v) / 10);
		jog_req <= 1'b0;
		conclude();
	end
endmodule
